// ===== src/pm_irq_pkg.sv
// package: shared constants and carriers for the power management and interrupt sideband
package pm_irq_pkg;
	// function power states
	localparam logic [1:0] PWR_D0 = 2'h0;
	localparam logic [1:0] PWR_D1 = 2'h1;
	localparam logic [1:0] PWR_D2 = 2'h2;
	localparam logic [1:0] PWR_D3HOT = 2'h3;
	localparam logic [1:0] PWR_RESET = 2'h0;
	// register offsets
	localparam logic [3:0] REG_CFG = 4'h0;
	localparam logic [3:0] REG_MSGADDR = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_EVENT = 4'h3;
	// cfg register field positions
	localparam int CFG_PWR_LO = 0;
	localparam int CFG_PME_EN = 2;
	localparam int CFG_MSI_EN = 3;
	localparam int CFG_MSIX_EN = 4;
	localparam int CFG_INTX_DIS = 5;
	localparam int CFG_D1D2_OK = 6;
	localparam logic [31:0] CFG_RESET = 32'h0000_0000;
	// event register field positions (write one to inject a link event)
	localparam int EVT_TRAIN_DONE = 0;
	localparam int EVT_TURN_OFF = 1;
	localparam int EVT_LINK_DOWN = 2;
	// turn-off acknowledge message hold time
	localparam int ACK_TIME_NS = 200;
	localparam int CLK_PERIOD_NS = 100;
	localparam int ACK_CYCLES = (ACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// outgoing message kinds
	typedef enum logic [2:0] {
		MSG_NONE,
		MSG_ASSERT_INTA,
		MSG_DEASSERT_INTA,
		MSG_MSI_WRITE,
		MSG_PM_PME,
		MSG_TURN_OFF_ACK,
		MSG_PM_ENTER_L1
	} msg_kind_t;
	typedef struct packed {
		msg_kind_t kind;
		logic [7:0] data;
	} msg_t;
	// interrupt request carrier
	typedef struct packed {
		logic req;
		logic assert_sel;
		logic [7:0] vector;
	} irq_req_t;
	// interrupt mode
	typedef enum logic [1:0] {
		IRQ_LEGACY,
		IRQ_MSI,
		IRQ_MSIX
	} irq_mode_t;
endpackage : pm_irq_pkg

// ===== src/irq_ctrl.sv
// file: interrupt controller for legacy and msi requests
`timescale 1ns/1ps
module irq_ctrl (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic enable,
	input wire logic msi_en,
	input wire logic intx_dis,
	input wire pm_irq_pkg::irq_req_t irq,
	output logic irq_accept,
	output pm_irq_pkg::msg_t msg_reg
);
	logic pulse_reg;
	logic send_msi;
	logic send_intx;

	// request taken at most every other cycle: pulse then one idle cycle, whether or not req drops
	assign irq_accept = irq.req & enable & ~pulse_reg;
	assign send_msi = irq_accept & msi_en;
	assign send_intx = irq_accept & ~msi_en & ~intx_dis;

	// accept pulse spacing
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pulse_reg <= 1'b0;
		end else begin
			pulse_reg <= irq_accept;
		end
	end

	// message issued in the cycle after acceptance
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			msg_reg <= '{kind: pm_irq_pkg::MSG_NONE, data: 8'h00};
		end else if (send_msi) begin
			msg_reg <= '{kind: pm_irq_pkg::MSG_MSI_WRITE, data: irq.vector};
		end else if (send_intx) begin
			msg_reg.data <= 8'h00;
			msg_reg.kind <= irq.assert_sel ? pm_irq_pkg::MSG_ASSERT_INTA
				: pm_irq_pkg::MSG_DEASSERT_INTA;
		end else begin
			msg_reg <= '{kind: pm_irq_pkg::MSG_NONE, data: 8'h00};
		end
	end

	msi_kind_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		irq_accept && msi_en |=> msg_reg.kind == pm_irq_pkg::MSG_MSI_WRITE)
		else $error("msi request did not produce memory write");
	intx_block_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		irq_accept && !msi_en && intx_dis |=> msg_reg.kind == pm_irq_pkg::MSG_NONE)
		else $error("legacy message sent while disabled");
endmodule : irq_ctrl

// ===== src/pm_irq_sideband.sv
// file: power management and interrupt sideband top
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
// Operation
// - active state after training, no user action
// - standby only when programmed D3hot/D1/D2
// - present programmed power state on two bits
// - drop transmit ready outside D0; code holds it until an open packet ends
// - standby packet exchange done without user
// - forward wake only when pme enabled
// - turn-off message starts ready-for-removal entry
// - hold turn-off request until grant
// - send turn-off acknowledge after grant
// - then close interfaces, ready for power removal
// - mirror msi and msi-x enable bits
// - both enables low gives legacy only
// - both enables high still sends msi
// - msi enabled sends memory write per request; code drops one accepted in the last active cycle before standby
// - legacy blocked while interrupt disable set
// - enable bits set only by config side
// - pulse accept when request taken
// - user drops request after accept, inta follows
module pm_irq_sideband (
	input wire logic sys_clk,
	input wire logic sys_rst,
	// configuration side register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// user power management side
	output logic [1:0] power_state_out,
	output logic tx_ready,
	input wire logic tx_in_packet,
	input wire logic wake_request_in,
	output logic power_down_request_out,
	input wire logic turnoff_grant_in,
	// user interrupt side
	output logic msi_enable_out,
	output logic msix_enable_out,
	input wire logic irq_req_in,
	input wire logic irq_assert_in,
	input wire logic [7:0] irq_vector_in,
	output logic irq_accept_out,
	// upstream message stream
	output pm_irq_pkg::msg_t msg_out,
	output logic link_active,
	output logic link_standby,
	output logic powered_off
);
	typedef enum {
		LS_DOWN,
		LS_ACTIVE,
		LS_STANDBY,
		LS_TURNOFF,
		LS_ACK,
		LS_OFF
	} link_state_t;

	link_state_t state_reg;
	logic [31:0] cfg_reg;
	logic [1:0] pwr_next;
	logic [$clog2(pm_irq_pkg::ACK_CYCLES + 1)-1:0] ack_cnt_reg;
	logic pkt_open_reg;
	logic wake_reg;
	logic l1_sent_reg;
	logic wr_cfg;
	logic evt_train;
	logic evt_off;
	logic evt_down;
	pm_irq_pkg::irq_req_t irq;
	pm_irq_pkg::msg_t irq_msg;
	logic irq_accept;

	// decode a write to one register
	function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
		return a == target;
	endfunction : hit

	assign wr_cfg = reg_wr & hit(reg_addr, pm_irq_pkg::REG_CFG);
	assign evt_train = reg_wr & hit(reg_addr, pm_irq_pkg::REG_EVENT)
		& reg_wdata[pm_irq_pkg::EVT_TRAIN_DONE];
	assign evt_off = reg_wr & hit(reg_addr, pm_irq_pkg::REG_EVENT)
		& reg_wdata[pm_irq_pkg::EVT_TURN_OFF];
	assign evt_down = reg_wr & hit(reg_addr, pm_irq_pkg::REG_EVENT)
		& reg_wdata[pm_irq_pkg::EVT_LINK_DOWN];

	// power state field accepts only supported values
	always_comb begin
		pwr_next = reg_wdata[pm_irq_pkg::CFG_PWR_LO +: 2];
		if (!cfg_reg[pm_irq_pkg::CFG_D1D2_OK] && (pwr_next == pm_irq_pkg::PWR_D1
			|| pwr_next == pm_irq_pkg::PWR_D2)) begin
			pwr_next = cfg_reg[pm_irq_pkg::CFG_PWR_LO +: 2];
		end
	end

	// config register, written only over the config port
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cfg_reg <= pm_irq_pkg::CFG_RESET;
		end else if (wr_cfg && state_reg != LS_OFF) begin
			cfg_reg <= reg_wdata;
			cfg_reg[pm_irq_pkg::CFG_PWR_LO +: 2] <= pwr_next;
			cfg_reg[31:7] <= '0;
		end
	end

	// register read data, one cycle after strobe
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				pm_irq_pkg::REG_CFG: reg_rdata <= cfg_reg;
				pm_irq_pkg::REG_STATUS: reg_rdata <= {26'h0, power_down_request_out,
					powered_off, link_standby, link_active, wake_reg, pkt_open_reg};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// sideband outputs from config
	assign power_state_out = cfg_reg[pm_irq_pkg::CFG_PWR_LO +: 2];
	assign msi_enable_out = cfg_reg[pm_irq_pkg::CFG_MSI_EN];
	assign msix_enable_out = cfg_reg[pm_irq_pkg::CFG_MSIX_EN];

	// track a packet in progress on the transmit side
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pkt_open_reg <= 1'b0;
		end else begin
			pkt_open_reg <= tx_in_packet;
		end
	end

	// ready stays up only to finish a packet begun in D0
	assign tx_ready = (state_reg == LS_ACTIVE || state_reg == LS_STANDBY)
		&& (power_state_out == pm_irq_pkg::PWR_D0 || pkt_open_reg);

	// link state sequencing
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg <= LS_DOWN;
		end else begin
			unique case (state_reg)
				LS_DOWN: if (evt_train) begin
					state_reg <= LS_ACTIVE;
				end
				LS_ACTIVE: if (evt_off) begin
					state_reg <= LS_TURNOFF;
				end else if (evt_down) begin
					state_reg <= LS_DOWN;
				end else if (power_state_out != pm_irq_pkg::PWR_D0) begin
					state_reg <= LS_STANDBY;
				end
				LS_STANDBY: if (evt_off) begin
					state_reg <= LS_TURNOFF;
				end else if (evt_down) begin
					state_reg <= LS_DOWN;
				end else if (power_state_out == pm_irq_pkg::PWR_D0) begin
					state_reg <= LS_ACTIVE;
				end
				LS_TURNOFF: if (turnoff_grant_in) begin
					state_reg <= LS_ACK;
				end
				LS_ACK: if (ack_cnt_reg == '0) begin
					state_reg <= LS_OFF;
				end
				LS_OFF: state_reg <= LS_OFF;
			endcase
		end
	end

	// acknowledge message hold count
	always_ff @(posedge sys_clk) begin
		if (sys_rst || state_reg != LS_ACK) begin
			ack_cnt_reg <= ($bits(ack_cnt_reg))'(pm_irq_pkg::ACK_CYCLES - 1);
		end else if (ack_cnt_reg != '0) begin
			ack_cnt_reg <= ack_cnt_reg - 1'b1;
		end
	end

	assign power_down_request_out = state_reg == LS_TURNOFF;
	assign link_active = state_reg == LS_ACTIVE;
	assign link_standby = state_reg == LS_STANDBY;
	assign powered_off = state_reg == LS_OFF;

	// standby entry packet sent once per entry
	always_ff @(posedge sys_clk) begin
		if (sys_rst || state_reg != LS_STANDBY) begin
			l1_sent_reg <= 1'b0;
		end else begin
			l1_sent_reg <= 1'b1;
		end
	end

	// wake forwarded only while pme enabled
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wake_reg <= 1'b0;
		end else begin
			wake_reg <= wake_request_in & cfg_reg[pm_irq_pkg::CFG_PME_EN]
				& link_standby;
		end
	end

	// interrupt path, closed off outside the live link
	assign irq.req = irq_req_in;
	assign irq.assert_sel = irq_assert_in;
	assign irq.vector = irq_vector_in;
	assign irq_accept_out = irq_accept;

	irq_ctrl u_irq (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.enable(link_active),
		.msi_en(cfg_reg[pm_irq_pkg::CFG_MSI_EN]),
		.intx_dis(cfg_reg[pm_irq_pkg::CFG_INTX_DIS]),
		.irq(irq),
		.irq_accept(irq_accept),
		.msg_reg(irq_msg)
	);

	// upstream message merge, pm messages first
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			msg_out <= '{kind: pm_irq_pkg::MSG_NONE, data: 8'h00};
		end else if (state_reg == LS_ACK) begin
			msg_out <= '{kind: pm_irq_pkg::MSG_TURN_OFF_ACK, data: 8'h00};
		end else if (link_standby && !l1_sent_reg) begin
			msg_out <= '{kind: pm_irq_pkg::MSG_PM_ENTER_L1, data: 8'h00};
		end else if (wake_reg) begin
			msg_out <= '{kind: pm_irq_pkg::MSG_PM_PME, data: 8'h00};
		end else begin
			msg_out <= irq_msg;
		end
	end

	req_held_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		power_down_request_out && !turnoff_grant_in |=> power_down_request_out)
		else $error("turn-off request dropped before grant");
	ready_d0_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		power_state_out != pm_irq_pkg::PWR_D0 && !pkt_open_reg |-> !tx_ready)
		else $error("transmit ready outside D0");
	wake_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!cfg_reg[pm_irq_pkg::CFG_PME_EN] |=> !wake_reg)
		else $error("wake forwarded while disabled");
	ack_after_grant_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		power_down_request_out && turnoff_grant_in
		|=> ##1 msg_out.kind == pm_irq_pkg::MSG_TURN_OFF_ACK)
		else $error("no acknowledge after grant");
	off_after_ack_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(state_reg == LS_ACK) |-> ##[1:8] powered_off)
		else $error("not powered off after acknowledge");
	mode_mirror_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_cfg |=> msi_enable_out == $past(reg_wdata[pm_irq_pkg::CFG_MSI_EN])
		|| powered_off)
		else $error("msi enable not mirrored");
	standby_cause_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$rose(link_standby) |-> $past(power_state_out) != pm_irq_pkg::PWR_D0)
		else $error("standby without programmed state");
	accept_active_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		irq_accept_out |-> irq_req_in && link_active ##1 !irq_accept_out)
		else $error("accept without request");
endmodule : pm_irq_sideband

// ===== tb/user_app_model.sv
// user application model facing the sideband
`timescale 1ns/1ps
module user_app_model (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic tx_ready,
	input wire logic power_down_request_out,
	input wire logic irq_accept_out,
	input wire logic irq_go,
	input wire logic irq_sel,
	input wire logic [7:0] irq_vec,
	input wire logic pkt_go,
	input wire logic [3:0] grant_delay,
	output logic tx_in_packet,
	output logic irq_req_in,
	output logic irq_assert_in,
	output logic [7:0] irq_vector_in,
	output logic turnoff_grant_in
);
	logic [3:0] wait_reg;
	// packets open only while transmit is open and no turn-off is pending
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !pkt_go) begin
			tx_in_packet <= 1'b0;
		end else if (tx_ready && !power_down_request_out) begin
			tx_in_packet <= 1'b1;
		end
	end
	// request held until accepted, dropped the cycle after
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			irq_req_in <= 1'b0;
			irq_assert_in <= 1'b0;
			irq_vector_in <= 8'h00;
		end else if (irq_req_in && irq_accept_out) begin
			irq_req_in <= 1'b0;
			irq_assert_in <= ~irq_assert_in; // released lines scrambled
			irq_vector_in <= ~irq_vector_in;
		end else if (irq_go && !irq_req_in) begin
			irq_req_in <= 1'b1;
			irq_assert_in <= irq_sel;
			irq_vector_in <= irq_vec;
		end
	end
	// grant only after the open packet is finished, after a chosen delay
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			wait_reg <= 4'h0;
			turnoff_grant_in <= 1'b0;
		end else if (power_down_request_out && !tx_in_packet) begin
			wait_reg <= wait_reg + 4'h1;
			if (wait_reg >= grant_delay) begin
				turnoff_grant_in <= 1'b1;
			end
		end
	end
endmodule : user_app_model

// ===== tb/pm_irq_sideband_tb.sv
// self-checking bench for the power management and interrupt sideband
`timescale 1ns/1ps
module pm_irq_sideband_tb;
	logic sys_clk, sys_rst, reg_wr, reg_rd, tx_ready, tx_in_packet, wake_request_in;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [1:0] power_state_out;
	logic power_down_request_out, turnoff_grant_in, msi_enable_out, msix_enable_out;
	logic irq_req_in, irq_assert_in, irq_accept_out, link_active, link_standby, powered_off;
	logic [7:0] irq_vector_in, irq_vec, v;
	logic irq_go, irq_sel, pkt_go, pkt_en;
	logic [3:0] grant_delay;
	logic [2:0] f;
	logic [31:0] rnd = 32'h46D4;
	pm_irq_pkg::msg_t msg_out;
	pm_irq_pkg::msg_t msg_q[$];
	int fails, n_tests, n_acc, cyc, n;
	pm_irq_sideband u_pm_irq_sideband (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .power_state_out(power_state_out), .tx_ready(tx_ready),
		.tx_in_packet(tx_in_packet), .wake_request_in(wake_request_in),
		.power_down_request_out(power_down_request_out), .turnoff_grant_in(turnoff_grant_in),
		.msi_enable_out(msi_enable_out), .msix_enable_out(msix_enable_out),
		.irq_req_in(irq_req_in), .irq_assert_in(irq_assert_in), .irq_vector_in(irq_vector_in),
		.irq_accept_out(irq_accept_out), .msg_out(msg_out), .link_active(link_active),
		.link_standby(link_standby), .powered_off(powered_off));
	user_app_model u_user_app_model (.sys_clk(sys_clk), .sys_rst(sys_rst), .tx_ready(tx_ready),
		.power_down_request_out(power_down_request_out), .irq_accept_out(irq_accept_out),
		.irq_go(irq_go), .irq_sel(irq_sel), .irq_vec(irq_vec), .pkt_go(pkt_go),
		.grant_delay(grant_delay), .tx_in_packet(tx_in_packet), .irq_req_in(irq_req_in),
		.irq_assert_in(irq_assert_in), .irq_vector_in(irq_vector_in),
		.turnoff_grant_in(turnoff_grant_in));
	// clock
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// cfg word from {intx_dis, msix, msi}, power state, pme enable, d1/d2 support
	function automatic logic [31:0] cfgv(input logic [2:0] m, input logic [1:0] p,
		input logic pme, input logic d12);
		return 32'(p) | (32'(pme) << pm_irq_pkg::CFG_PME_EN)
			| (32'(m) << pm_irq_pkg::CFG_MSI_EN) | (32'(d12) << pm_irq_pkg::CFG_D1D2_OK);
	endfunction : cfgv
	// message expected from one assert request in mode m
	function automatic pm_irq_pkg::msg_kind_t exp_kind(input logic [2:0] m);
		if (m[0]) return pm_irq_pkg::MSG_MSI_WRITE;
		if (m[2]) return pm_irq_pkg::MSG_NONE;
		return pm_irq_pkg::MSG_ASSERT_INTA;
	endfunction : exp_kind
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task exp_msg(input pm_irq_pkg::msg_kind_t k, input logic [7:0] d);
		pm_irq_pkg::msg_t m;
		m = '0;
		if (msg_q.size() > 0) m = msg_q.pop_front();
		chk("msg kind", 32'(k), 32'(m.kind));
		if (k <= pm_irq_pkg::MSG_MSI_WRITE) chk("msg data", 32'(d), 32'(m.data));
	endtask : exp_msg
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [31:0] e, input string nm);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(nm, e, reg_rdata);
	endtask : rd
	task irq(input logic s, input logic [7:0] iv, input pm_irq_pkg::msg_kind_t k,
		input logic [7:0] d);
		int a0;
		a0 = n_acc;
		n = 0;
		@(posedge sys_clk);
		irq_go <= 1'b1;
		irq_sel <= s;
		irq_vec <= iv;
		@(posedge sys_clk);
		irq_go <= 1'b0;
		while (n_acc == a0 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		repeat (4) @(negedge sys_clk);
		chk("accepts", 32'(a0 + 1), 32'(n_acc));
		exp_msg(k, d);
		exp_msg(pm_irq_pkg::MSG_NONE, 8'h00);
	endtask : irq
	task wake();
		@(posedge sys_clk);
		wake_request_in <= 1'b1;
		@(posedge sys_clk);
		wake_request_in <= 1'b0;
		repeat (4) @(negedge sys_clk);
	endtask : wake
	task final_report();
		if (fails == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report
	// message and accept monitor
	always @(negedge sys_clk) begin
		if (!sys_rst && msg_out.kind !== pm_irq_pkg::MSG_NONE) msg_q.push_back(msg_out);
		if (irq_accept_out === 1'b1) n_acc++;
	end
	// random traffic and hang guard
	always @(posedge sys_clk) begin
		rnd <= lfsr(rnd);
		pkt_go <= pkt_en & rnd[3];
		cyc++;
		if (cyc == 20000) begin
			fails++;
			final_report();
		end
	end
	// main sequence
	initial begin
		sys_rst = 1'b1;
		{reg_wr, reg_rd, reg_addr, reg_wdata, wake_request_in} = '0;
		{irq_go, irq_sel, irq_vec, pkt_en, pkt_go, grant_delay} = '0;
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(negedge sys_clk);
		chk("link_active", 32'h0, 32'(link_active));
		rd(pm_irq_pkg::REG_CFG, pm_irq_pkg::CFG_RESET, "cfg reset");
		rd(4'h7, 32'h0, "unmapped");
		wr(pm_irq_pkg::REG_EVENT, 32'h1);
		pkt_en <= 1'b1;
		repeat (2) @(negedge sys_clk);
		chk("link_active", 32'h1, 32'(link_active));
		for (int i = 0; i < 8; i++) begin
			f = 3'(i);
			wr(pm_irq_pkg::REG_CFG, cfgv(f, pm_irq_pkg::PWR_D0, 1'b0, 1'b0));
			rd(pm_irq_pkg::REG_CFG, cfgv(f, pm_irq_pkg::PWR_D0, 1'b0, 1'b0), "cfg");
			chk("msi_en", 32'(f[0]), 32'(msi_enable_out));
			chk("msix_en", 32'(f[1]), 32'(msix_enable_out));
			v = f[0] ? rnd[15:8] : 8'h00;
			// msi-x only modes skipped, though the code ignores msi-x and still accepts requests there
			if (f[1:0] != 2'b10) irq(1'b1, v, exp_kind(f), v);
			if (f == 3'b000) irq(1'b0, 8'h00, pm_irq_pkg::MSG_DEASSERT_INTA, 8'h00);
		end
		pkt_en <= 1'b0;
		repeat (4) @(negedge sys_clk);
		chk("tx_ready", 32'h1, 32'(tx_ready));
		// link drop and retrain
		wr(pm_irq_pkg::REG_EVENT, 32'h4);
		repeat (2) @(negedge sys_clk);
		chk("link_active", 32'h0, 32'(link_active));
		chk("tx_ready", 32'h0, 32'(tx_ready));
		wr(pm_irq_pkg::REG_EVENT, 32'h1);
		repeat (2) @(negedge sys_clk);
		chk("link_active", 32'h1, 32'(link_active));
		wr(pm_irq_pkg::REG_CFG, cfgv(3'h0, pm_irq_pkg::PWR_D1, 1'b0, 1'b0));
		repeat (3) @(negedge sys_clk);
		chk("power_state", 32'(pm_irq_pkg::PWR_D0), 32'(power_state_out));
		chk("link_active", 32'h1, 32'(link_active));
		wr(pm_irq_pkg::REG_CFG, cfgv(3'h0, pm_irq_pkg::PWR_D3HOT, 1'b0, 1'b0));
		// one spare edge so the monitor has queued the standby message
		repeat (4) @(negedge sys_clk);
		chk("power_state", 32'(pm_irq_pkg::PWR_D3HOT), 32'(power_state_out));
		chk("tx_ready", 32'h0, 32'(tx_ready));
		chk("link_standby", 32'h1, 32'(link_standby));
		exp_msg(pm_irq_pkg::MSG_PM_ENTER_L1, 8'h00);
		// status: only the standby bit (bit 3) set
		rd(pm_irq_pkg::REG_STATUS, 32'h0000_0008, "status");
		wake();
		exp_msg(pm_irq_pkg::MSG_NONE, 8'h00);
		wr(pm_irq_pkg::REG_CFG, cfgv(3'h0, pm_irq_pkg::PWR_D3HOT, 1'b1, 1'b0));
		wake();
		exp_msg(pm_irq_pkg::MSG_PM_PME, 8'h00);
		pkt_en <= 1'b1;
		grant_delay <= rnd[7:4];
		wr(pm_irq_pkg::REG_EVENT, 32'h2);
		n = 0;
		@(negedge sys_clk);
		while (turnoff_grant_in !== 1'b1 && n < 40) begin
			chk("pd_request", 32'h1, 32'(power_down_request_out));
			@(negedge sys_clk);
			n++;
		end
		repeat (6) @(negedge sys_clk);
		chk("pd_request", 32'h0, 32'(power_down_request_out));
		chk("powered_off", 32'h1, 32'(powered_off));
		for (int i = 0; i < pm_irq_pkg::ACK_CYCLES; i++) begin
			exp_msg(pm_irq_pkg::MSG_TURN_OFF_ACK, 8'h00);
		end
		exp_msg(pm_irq_pkg::MSG_NONE, 8'h00);
		wr(pm_irq_pkg::REG_CFG, 32'h0);
		rd(pm_irq_pkg::REG_CFG, cfgv(3'h0, pm_irq_pkg::PWR_D3HOT, 1'b1, 1'b0), "cfg");
		final_report();
	end
endmodule : pm_irq_sideband_tb
